// file: eil_pkg.sv
/*
 * Shared constants and types for the external interrupt latch.
 * Assumes an APB master on the same clock as the latch.
 */
package eil_pkg;

    // Register byte offsets on the APB.
    localparam logic [7:0] EIL_OFF_SCR  = 8'h00;
    localparam logic [7:0] EIL_OFF_STAT = 8'h04;
    localparam logic [7:0] EIL_OFF_MASK = 8'h08;
    localparam logic [7:0] EIL_OFF_BFC  = 8'h0C;

    // Field positions in ext_int_status_control.
    localparam int EIL_MODE_BIT  = 0;
    localparam int EIL_REQUEST_MASK_BIT_BIT = 1;
    localparam int EIL_ACK_BIT   = 2;
    localparam int EIL_REQUEST_PENDING_FLAG_BIT  = 3;

    // Field positions in the event status and event mask registers.
    localparam int EIL_EV_SET_BIT = 0;
    localparam int EIL_EV_ACK_BIT = 1;
    localparam int EIL_EV_W       = 2;

    // Field position in break_flag_control_register.
    localparam int EIL_BREAK_CLEAR_ENABLE_BIT = 0;

    // Values after reset.
    localparam logic       EIL_RST_MODE  = 1'h0;
    localparam logic       EIL_RST_REQUEST_MASK_BIT = 1'h0;
    localparam logic       EIL_RST_BREAK_CLEAR_ENABLE  = 1'h0;
    localparam logic [1:0] EIL_RST_EV    = 2'h0;

    // Fixed vector locations, high byte then low byte.
    localparam logic [15:0] EIL_VEC_HI = 16'hFFFA;
    localparam logic [15:0] EIL_VEC_LO = 16'hFFFB;

    // APB request from the master, carried as one bundle.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } eil_apb_req_t;

endpackage

// file: eil_latch.sv
/*
 * External interrupt latch with its APB register file.
 * Holds the pin synchroniser, the falling-edge detector, the request latch
 * with its edge-only and edge-and-level clearing, the mask, the pending flag,
 * the break-state guard on software acknowledges, and a small event block
 * with a sticky status register, a mask register and one level output.
 * Assumes one clock, synchronous reset, an asynchronous active-low
 * interrupt pin, and vector fetch and break state from same-clock logic.
 * Assumes the pin has a pull-up outside, so a released pin reads high.
 * Assumes the APB master keeps to the setup and access phases; the slave
 * itself never stretches a transfer.
 */
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

module eil_latch (
    // Clock, reset and freeze.
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 clkEn,
    // APB slave.
    input  wire eil_pkg::eil_apb_req_t apbReq,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Pin and processor side.
    input  wire logic                 irqPin_n,
    input  wire logic                 vecFetch,
    input  wire logic                 breakState,
    output logic                      irqRequest,
    output logic                      pinLevel,
    output logic [15:0]               vecAddrHi,
    output logic [15:0]               vecAddrLo,
    // Event interrupt.
    output logic                      intOut
);
    import eil_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic                pinSync1;     // First synchroniser stage.
    logic                pinSync2;     // Second stage, safe to read.
    logic                pinPrev;      // Previous bus-cycle sample.
    logic                latch;        // The request latch.
    logic                ackSeen;      // Ack taken while pin still low.
    logic                mode;         // Edge-and-level select.
    logic                request_mask_bit;        // Request mask.
    logic                break_clear_enable;         // Break-clear enable.
    logic [EIL_EV_W-1:0] evStat;       // Sticky event bits.
    logic [EIL_EV_W-1:0] evMask;       // Event enables.
    logic                next_latch;
    logic                next_ackSeen;
    logic                next_mode;
    logic                next_request_mask_bit;
    logic                next_break_clear_enable;
    logic [EIL_EV_W-1:0] next_evStat;
    logic [EIL_EV_W-1:0] next_evMask;
    logic [31:0]         next_prdata;
    logic                fallEdge;     // Falling edge seen on the pin.
    logic                pinLow;       // Synchronised pin is low.
    logic                wrEn;         // APB write takes effect.
    logic                rdEn;         // APB read completes.
    logic                swAck;        // Software acknowledge accepted.
    logic                ack;          // Any acknowledge.
    logic                clr;          // Latch clear condition.

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    // True when the address selects the register at the given offset.
    function automatic logic hitReg(input logic [7:0] a,
                                    input logic [7:0] off);
        hitReg = (a == off);
    endfunction

    // True when the address selects any mapped register.
    function automatic logic mapped(input logic [7:0] a);
        mapped = hitReg(a, EIL_OFF_SCR) || hitReg(a, EIL_OFF_STAT) ||
                 hitReg(a, EIL_OFF_MASK) || hitReg(a, EIL_OFF_BFC);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge detector.

    // Two flops keep a metastable pin away from the edge logic.
    // During reset the chain keeps following the pin instead of being forced
    // high. Forcing it high would make a pin held low through reset look like
    // a fresh falling edge at release and latch a request that reset must drop.
    // The cost is that an edge landing inside a reset pulse is lost, which is
    // what a reset is expected to do anyway.
    always_ff @(posedge clk) begin
        if (rst) begin
            pinSync1 <= irqPin_n;
            pinSync2 <= pinSync1;
            pinPrev  <= pinSync2;
        end else if (clkEn) begin
            pinSync1 <= irqPin_n;
            pinSync2 <= pinSync1;
            pinPrev  <= pinSync2;
        end
    end

    // A high sample followed by a low one is the falling edge.
    assign fallEdge = pinPrev & ~pinSync2;
    assign pinLow   = ~pinSync2;
    // The branch instructions look at the pin level directly.
    assign pinLevel = pinSync2;

    ////////////////////////////////////////////////////////////////////////
    // APB slave.

    // The slave never waits, so every access ends in its first access cycle.
    // A write lands at the edge that closes the access cycle; a read clears
    // the event status at that same edge.
    // Keeping pready tied high means the read data must already be in a flop
    // when the access cycle starts, which is why it is loaded at setup.
    assign pready  = 1'h1;
    assign wrEn    = apbReq.psel & apbReq.penable & apbReq.pwrite;
    assign rdEn    = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
    // An unmapped address is answered with an error, not a hang.
    assign pslverr = apbReq.psel & apbReq.penable & ~mapped(apbReq.paddr);

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge and latch.

    // Software ack counts only outside break, or with break-clear enabled.
    always_comb begin
        swAck = wrEn & hitReg(apbReq.paddr, EIL_OFF_SCR) &
                apbReq.pwdata[EIL_ACK_BIT];
        if (breakState && !break_clear_enable) begin
            swAck = 1'h0;
        end
        // A cleared latch stays cleared after break ends.
        ack = vecFetch | swAck;
    end

    // Next latch state; a set always wins over a clear.
    // In edge-only mode one ack is enough. In edge-and-level mode an ack that
    // arrives while the pin is still low is parked in ackSeen, and the latch
    // only drops once the synchronised pin reads high again.
    // A new falling edge throws away a parked ack, so it needs its own ack.
    always_comb begin
        if (mode) begin
            // Both the ack and a high pin are needed, in any order.
            clr = (ack | ackSeen) & ~pinLow;
        end else begin
            // Edge-only mode ignores the pin level when clearing.
            clr = ack;
        end
        next_latch = fallEdge | (mode & pinLow) |
                     (latch & ~clr);
        // Remember an ack that came while the pin was still low.
        next_ackSeen = mode & latch & ~clr & ~fallEdge &
                       (ackSeen | ack);
    end

    // Latch registers; reset drops the request even with the pin low.
    always_ff @(posedge clk) begin
        if (rst) begin
            latch   <= 1'h0;
            ackSeen <= 1'h0;
        end else if (clkEn) begin
            latch   <= next_latch;
            ackSeen <= next_ackSeen;
        end
    end

    // The mask only gates the path to the priority logic.
    assign irqRequest = latch & ~request_mask_bit;

    ////////////////////////////////////////////////////////////////////////
    // Control registers and events.

    // Next values of the software-visible state.
    always_comb begin
        next_mode   = mode;
        next_request_mask_bit  = request_mask_bit;
        next_break_clear_enable   = break_clear_enable;
        next_evMask = evMask;
        next_evStat = evStat;
        if (wrEn && hitReg(apbReq.paddr, EIL_OFF_SCR)) begin
            next_mode  = apbReq.pwdata[EIL_MODE_BIT];
            next_request_mask_bit = apbReq.pwdata[EIL_REQUEST_MASK_BIT_BIT];
        end
        if (wrEn && hitReg(apbReq.paddr, EIL_OFF_MASK)) begin
            next_evMask = apbReq.pwdata[EIL_EV_W-1:0];
        end
        if (wrEn && hitReg(apbReq.paddr, EIL_OFF_BFC)) begin
            next_break_clear_enable = apbReq.pwdata[EIL_BREAK_CLEAR_ENABLE_BIT];
        end
        // Reading the status register clears it.
        if (rdEn && hitReg(apbReq.paddr, EIL_OFF_STAT)) begin
            next_evStat = EIL_RST_EV;
        end
        // Events are applied last so that a set beats a clearing read.
        if (next_latch && !latch) begin
            next_evStat[EIL_EV_SET_BIT] = 1'h1;
        end
        if (ack) begin
            next_evStat[EIL_EV_ACK_BIT] = 1'h1;
        end
    end

    // Control registers; mode comes up as edge-only.
    always_ff @(posedge clk) begin
        if (rst) begin
            mode   <= EIL_RST_MODE;
            request_mask_bit  <= EIL_RST_REQUEST_MASK_BIT;
            break_clear_enable   <= EIL_RST_BREAK_CLEAR_ENABLE;
            evStat <= EIL_RST_EV;
            evMask <= EIL_RST_EV;
        end else if (clkEn) begin
            mode   <= next_mode;
            request_mask_bit  <= next_request_mask_bit;
            break_clear_enable   <= next_break_clear_enable;
            evStat <= next_evStat;
            evMask <= next_evMask;
        end
    end

    // One level output for all unmasked sticky events.
    // It stays high until software reads the status register, so a slow
    // handler cannot miss an event that came and went before the read's setup cycle; one landing in that cycle is cleared unread.
    assign intOut = |(evStat & evMask);

    ////////////////////////////////////////////////////////////////////////
    // Read data.

    // Read data is built in the setup cycle, so it is a flop in access.
    always_comb begin
        next_prdata = prdata;
        if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
            next_prdata = 32'h0000_0000;
            if (hitReg(apbReq.paddr, EIL_OFF_SCR)) begin
                // The ack bit is write-only and reads zero.
                next_prdata[EIL_MODE_BIT]  = mode;
                next_prdata[EIL_REQUEST_MASK_BIT_BIT] = request_mask_bit;
                next_prdata[EIL_ACK_BIT]   = 1'h0;
                next_prdata[EIL_REQUEST_PENDING_FLAG_BIT]  = latch;
            end else if (hitReg(apbReq.paddr, EIL_OFF_STAT)) begin
                next_prdata[EIL_EV_W-1:0] = evStat;
            end else if (hitReg(apbReq.paddr, EIL_OFF_MASK)) begin
                next_prdata[EIL_EV_W-1:0] = evMask;
            end else if (hitReg(apbReq.paddr, EIL_OFF_BFC)) begin
                next_prdata[EIL_BREAK_CLEAR_ENABLE_BIT] = break_clear_enable;
            end
        end
    end

    // Read data and vector address flops.
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata    <= 32'h0000_0000;
            vecAddrHi <= EIL_VEC_HI;
            vecAddrLo <= EIL_VEC_LO;
        end else if (clkEn) begin
            prdata    <= next_prdata;
            vecAddrHi <= EIL_VEC_HI;
            vecAddrLo <= EIL_VEC_LO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !clkEn);

    // An edge must reach the latch in the next cycle.
    edge_sets_latch_a: assert property (
        fallEdge |=> latch)
        else $error("Falling edge did not set the latch.");

    // Edge-only mode clears on ack regardless of the pin.
    edge_only_clear_a: assert property (
        (!mode && ack && !fallEdge) |=> !latch)
        else $error("Edge-only ack did not clear the latch.");

    // With mode set, a low pin keeps the request pending.
    level_hold_a: assert property (
        (mode && pinLow && latch) |=> latch)
        else $error("Request dropped while pin low.");

    // An earlier ack clears once the pin has been high.
    late_release_a: assert property (
        (ackSeen && mode && !pinLow) |=> !latch)
        else $error("Stored ack did not clear on pin high.");

    // The mask gates the request path.
    mask_gates_a: assert property (
        request_mask_bit |-> !irqRequest)
        else $error("Masked request reached priority logic.");

    // Protected break leaves the latch untouched by writes.
    break_protect_a: assert property (
        (breakState && !break_clear_enable && !vecFetch && latch) |=> latch)
        else $error("Ack in protected break changed the latch.");

    // Enabled break lets the ack clear an edge-only request.
    break_clear_a: assert property (
        (breakState && break_clear_enable && swAck && !mode && !fallEdge)
        |=> !latch)
        else $error("Ack in enabled break did not clear.");

    // Pending flag reads back the latch after a read of the register.
    pending_read_a: assert property (
        (rdEn && hitReg(apbReq.paddr, EIL_OFF_SCR))
        |-> (prdata[EIL_REQUEST_PENDING_FLAG_BIT] == $past(latch, 1) &&
             !prdata[EIL_ACK_BIT]))
        else $error("Status read shows wrong pending or ack.");

    // A falling pin level sets the latch one cycle later.
    pin_level_a: assert property (
        $fell(pinLevel) |-> ##1 latch)
        else $error("Pin low without latching.");

    // A clear mask lets a latched request through at once.
    mask_open_a: assert property (
        (!request_mask_bit && latch) |-> irqRequest)
        else $error("Unmasked request withheld.");

    // Reset drops the latch and the mode bit even with the pin low.
    reset_clears_a: assert property (
        @(posedge clk) disable iff (1'b0)
        rst |=> (!latch && !mode))
        else $error("Reset left the latch or mode set.");

    // The vector locations never move.
    vector_fixed_a: assert property (
        (vecAddrHi == EIL_VEC_HI) && (vecAddrLo == EIL_VEC_LO))
        else $error("Vector location changed.");

    // Main scenarios.
    cov_edge_ack_c: cover property (fallEdge ##[1:20] (latch && ack));
    cov_level_mode_c: cover property (mode && ackSeen ##[1:50] !latch);
    cov_break_c: cover property (breakState && break_clear_enable && swAck);
    cov_int_c: cover property ($rose(intOut));

endmodule

// file: eil_pin_src.sv
/*
 * Model of the external source that pulls the interrupt pin low.
 * Assumes the bench clock; the pin has a pull-up, so a release reads high.
 */
`timescale 1ns/1ps

module eil_pin_src (
    // Clock and command from the bench.
    input  wire logic clk,
    input  wire logic pullLow,
    // Pin as seen by the latch.
    output logic      irqPin_n
);
    // The source only changes the pin just after an edge; released, the pull-up wins.
    always_ff @(posedge clk) begin
        irqPin_n <= ~pullLow;
    end
endmodule

// file: tb.sv
/*
 * Self-checking bench for the external interrupt latch.
 * Assumes eil_pkg, eil_latch and eil_pin_src are compiled before it.
 */
`timescale 1ns/1ps

module tb;
    import eil_pkg::*;
    // Pin source flop, two sync flops, edge compare and latch, plus margin.
    localparam int PIN_LAT = 6;
    logic         clk;
    logic         rst;
    logic         clkEn;
    eil_apb_req_t req;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         irqPin_n;
    logic         pullLow;
    logic         vecFetch;
    logic         breakState;
    logic         irqRequest;
    logic         pinLevel;
    logic [15:0]  vecHi;
    logic [15:0]  vecLo;
    logic         intOut;
    int           error_cnt;
    int           n_checks;
    logic [31:0]  rd;
    logic         err;

    ////////////////////////////////////////////////////////////////////////
    eil_latch DUT (.clk(clk), .rst(rst), .clkEn(clkEn), .apbReq(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irqPin_n(irqPin_n), .vecFetch(vecFetch),
        .breakState(breakState), .irqRequest(irqRequest), .pinLevel(pinLevel),
        .vecAddrHi(vecHi), .vecAddrLo(vecLo), .intOut(intOut));
    eil_pin_src src (.clk(clk), .pullLow(pullLow), .irqPin_n(irqPin_n));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count; case inequality so an unknown never matches.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // Reads the control register and judges the pending flag; ack must read 0.
    task automatic request_pending_flag(input logic e);
        apb(1'b0, EIL_OFF_SCR, 32'h0);
        chk("pending", 32'(e), 32'(rd[EIL_REQUEST_PENDING_FLAG_BIT]));
        chk("ack readback", 32'h0, 32'(rd[EIL_ACK_BIT]));
    endtask

    // Moves the pin and lets the synchroniser and latch settle.
    task automatic pin(input logic low);
        @(posedge clk);
        pullLow <= low;
        repeat (PIN_LAT) @(posedge clk);
    endtask

    // One-cycle vector fetch pulse from the processor side.
    task automatic fetch();
        @(posedge clk);
        vecFetch <= 1'b1;
        @(posedge clk);
        vecFetch <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        apb(1'b0, EIL_OFF_SCR, 32'h0);
        chk("scr reset", 32'h0, rd);
        chk("vector hi", 32'h0000FFFA, 32'(vecHi));
        chk("vector lo", 32'h0000FFFB, 32'(vecLo));
        chk("pin level", 32'h1, 32'(pinLevel));
        $display("test reset done");
    endtask

    // Edge mode: set, mask, poll, ack with the pin low, set again, fetch.
    task automatic t_edge();
        apb(1'b1, EIL_OFF_MASK, 32'h3);
        pin(1'b1);
        chk("pin low", 32'h0, 32'(pinLevel));
        chk("request", 32'h1, 32'(irqRequest));
        chk("event int", 32'h1, 32'(intOut));
        apb(1'b1, EIL_OFF_SCR, 32'h2);
        @(posedge clk);
        chk("masked", 32'h0, 32'(irqRequest));
        request_pending_flag(1'b1);
        chk("mask bit", 32'h1, 32'(rd[EIL_REQUEST_MASK_BIT_BIT]));
        apb(1'b1, EIL_OFF_SCR, 32'h6);
        request_pending_flag(1'b0);
        apb(1'b0, EIL_OFF_STAT, 32'h0);
        chk("events", 32'h3, rd);
        apb(1'b0, EIL_OFF_STAT, 32'h0);
        chk("events cleared", 32'h0, rd);
        chk("event int off", 32'h0, 32'(intOut));
        apb(1'b1, EIL_OFF_SCR, 32'h0);
        pin(1'b0);
        pin(1'b1);
        request_pending_flag(1'b1);
        fetch();
        request_pending_flag(1'b0);
        pin(1'b0);
        $display("test edge done");
    endtask

    // Edge and level mode: ack and pin release in both orders.
    task automatic t_level();
        apb(1'b1, EIL_OFF_SCR, 32'h1);
        pin(1'b1);
        apb(1'b1, EIL_OFF_SCR, 32'h5);
        request_pending_flag(1'b1);
        pin(1'b0);
        request_pending_flag(1'b0);
        pin(1'b1);
        pin(1'b0);
        request_pending_flag(1'b1);
        fetch();
        request_pending_flag(1'b0);
        $display("test level done");
    endtask

    // Break state: ack ignored without the enable, honoured with it.
    task automatic t_break();
        apb(1'b1, EIL_OFF_SCR, 32'h0);
        breakState <= 1'b1;
        pin(1'b1);
        apb(1'b1, EIL_OFF_SCR, 32'h4);
        request_pending_flag(1'b1);
        apb(1'b1, EIL_OFF_BFC, 32'h1);
        apb(1'b1, EIL_OFF_SCR, 32'h4);
        request_pending_flag(1'b0);
        breakState <= 1'b0;
        request_pending_flag(1'b0);
        apb(1'b1, EIL_OFF_BFC, 32'h0);
        pin(1'b0);
        $display("test break done");
    endtask

    // Reset with the pin held low in level mode, then an unmapped access.
    task automatic t_rst_bus();
        apb(1'b1, EIL_OFF_SCR, 32'h1);
        pin(1'b1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (PIN_LAT) @(posedge clk);
        chk("request after reset", 32'h0, 32'(irqRequest));
        apb(1'b0, EIL_OFF_SCR, 32'h0);
        chk("scr after reset", 32'h0, rd);
        pin(1'b0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped read", 32'h0, rd);
        chk("unmapped err", 32'h1, 32'(err));
        $display("test reset and bus done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Single place where the run ends.
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Free-running 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Watchdog sized well beyond the roughly two hundred cycles the tests need.
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        conclude();
    end

    // Main sequence.
    initial begin
        clkEn = 1'b1;
        rst = 1'b1;
        req = '0;
        pullLow = 1'b0;
        vecFetch = 1'b0;
        breakState = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_edge();
        t_level();
        t_break();
        t_rst_bus();
        conclude();
    end
endmodule
